// *** core/adc_serial_port.sv ***
// Serial port with combined data-out and ready pin
`default_nettype none
module adc_serial_port
    import adc_port_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    input wire logic conv_done_i,
    input wire logic pre_update_i,
    input wire logic [DATA_W-1:0] conv_data_i,
    output logic [REG_W-1:0] mode_reg_o,
    output logic part_reset_o
);
    // ------------------------------------------------
    // Reset release and core state
    // ------------------------------------------------
    logic rst_s1;
    logic rst_n;
    logic ready;
    logic next_ready;
    logic [DATA_W-1:0] data_reg;
    logic [DATA_W-1:0] next_data_reg;
    logic [REG_W-1:0] mode_reg;
    logic [REG_W-1:0] next_mode_reg;
    logic rd_tg_s1;
    logic rd_tg_s2;
    logic rd_tg_s3;
    logic rs_tg_s1;
    logic rs_tg_s2;
    logic rs_tg_s3;
    logic wr_tg_s1;
    logic wr_tg_s2;
    logic wr_tg_s3;
    logic wr_ev;
    logic data_read_ev;
    logic wipe_ev;
    logic buf_in_ready;
    logic buf_out_valid;
    wr_word_t buf_out;
    logic cread_s1;
    logic cread;
    logic rdy_s1;
    logic rdy_l;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ------------------------------------------------
    // Link clock domain
    // ------------------------------------------------
    link_state_t state;
    link_state_t next_state;
    logic [CMD_W-1:0] cmd;
    logic [CMD_W-1:0] next_cmd;
    logic [DATA_W-1:0] in_sr;
    logic [DATA_W-1:0] next_in_sr;
    logic [DATA_W-1:0] out_sr;
    logic [DATA_W-1:0] next_out_sr;
    logic [BIT_CNT_W-1:0] bits;
    logic [BIT_CNT_W-1:0] next_bits;
    logic [ONES_CNT_W-1:0] ones;
    logic [ONES_CNT_W-1:0] next_ones;
    logic rd_tg;
    logic next_rd_tg;
    logic rs_tg;
    logic next_rs_tg;
    logic wr_valid;
    logic next_wr_valid;
    wr_word_t wr_word;
    wr_word_t next_wr_word;
    logic creading;
    logic next_creading;
    logic shift_first;
    logic next_shift_first;
    logic lrst_s1;
    logic lrst_n;

    function automatic logic [BIT_CNT_W-1:0] reg_len(input logic [1:0] rs);
        reg_len = (rs == RS_DATA) ? BIT_CNT_W'(DATA_W - 1) : BIT_CNT_W'(REG_W - 1);
    endfunction

    always_ff @(posedge sclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lrst_s1 <= 1'b0;
            lrst_n <= 1'b0;
        end
        else
        begin
            lrst_s1 <= 1'b1;
            lrst_n <= lrst_s1;
        end
    end

    always_comb
    begin
        next_state = state;
        next_cmd = cmd;
        next_in_sr = in_sr;
        next_bits = bits;
        next_rd_tg = rd_tg;
        next_rs_tg = rs_tg;
        next_wr_valid = wr_valid;
        next_wr_word = wr_word;
        next_creading = creading && cread;
        next_ones = din_i ? ones + ONES_CNT_W'(1) : '0;
        if (!cs_n_i)
        begin
            next_in_sr = {in_sr[DATA_W-2:0], din_i};
            case (state)
                ST_CMD:
                begin
                    if (bits == '0 && din_i && !creading)
                    begin
                        next_bits = '0;
                    end
                    else if (creading)
                    begin
                        next_state = ST_READ;
                        next_bits = reg_len(RS_DATA);
                        next_cmd = {2'b00, RS_DATA, 1'b1, 1'b1, 2'b00};
                    end
                    else if (bits == BIT_CNT_W'(CMD_W - 1))
                    begin
                        next_cmd = {in_sr[CMD_W-2:0], din_i};
                        next_bits = '0;
                        if (next_cmd[CMD_RW_BIT])
                        begin
                            next_state = ST_READ;
                            next_bits = reg_len(next_cmd[CMD_RS_HI:CMD_RS_LO]);
                            next_creading = next_cmd[CMD_CREAD_BIT]
                                && next_cmd[CMD_RS_HI:CMD_RS_LO] == RS_DATA;
                        end
                        else if (next_cmd[CMD_RS_HI:CMD_RS_LO] != RS_COMM)
                        begin
                            next_state = ST_WRITE;
                            next_bits = BIT_CNT_W'(REG_W - 1);
                        end
                        next_cmd[CMD_WEN_BIT] = 1'b0;
                    end
                    else
                    begin
                        next_bits = bits + BIT_CNT_W'(1);
                    end
                end
                ST_WRITE:
                begin
                    if (bits == '0)
                    begin
                        next_wr_word.rs = cmd[CMD_RS_HI:CMD_RS_LO];
                        next_wr_word.value = {in_sr[REG_W-2:0], din_i};
                        next_wr_valid = ~wr_valid;
                        next_state = ST_CMD;
                    end
                    else
                    begin
                        next_bits = bits - BIT_CNT_W'(1);
                    end
                end
                ST_READ:
                begin
                    if (bits == '0)
                    begin
                        next_state = ST_CMD;
                        if (cmd[CMD_RS_HI:CMD_RS_LO] == RS_DATA)
                        begin
                            next_rd_tg = ~rd_tg;
                        end
                    end
                    else
                    begin
                        next_bits = bits - BIT_CNT_W'(1);
                    end
                end
                default:
                begin
                    next_state = ST_CMD;
                end
            endcase
        end
        if (!cs_n_i && ones == ONES_CNT_W'(RESET_ONES - 1) && din_i)
        begin
            next_rs_tg = ~rs_tg;
            next_state = ST_CMD;
            next_bits = '0;
            next_creading = 1'b0;
            next_ones = '0;
        end
    end

    always_ff @(posedge sclk_i or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            state <= ST_CMD;
            cmd <= '0;
            in_sr <= '0;
            bits <= '0;
            ones <= '0;
            rd_tg <= 1'b0;
            rs_tg <= 1'b0;
            wr_valid <= 1'b0;
            wr_word <= '0;
            creading <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cmd <= next_cmd;
            in_sr <= next_in_sr;
            bits <= next_bits;
            ones <= next_ones;
            rd_tg <= next_rd_tg;
            rs_tg <= next_rs_tg;
            wr_valid <= next_wr_valid;
            wr_word <= next_wr_word;
            creading <= next_creading;
        end
    end

    always_comb
    begin
        next_shift_first = (state == ST_READ);
        next_out_sr = out_sr;
        if (state == ST_READ && shift_first)
        begin
            next_out_sr = {out_sr[DATA_W-2:0], 1'b0};
        end
        else if (state == ST_READ)
        begin
            case (cmd[CMD_RS_HI:CMD_RS_LO])
                RS_DATA: next_out_sr = data_reg;
                RS_MODE: next_out_sr = {mode_reg, 16'h0000};
                default: next_out_sr = {~rdy_l, STATUS_BASE[6:0], 16'h0000};
            endcase
        end
    end

    always_ff @(negedge sclk_i or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            out_sr <= '0;
            shift_first <= 1'b0;
        end
        else
        begin
            out_sr <= next_out_sr;
            shift_first <= next_shift_first;
        end
    end

    always_ff @(posedge sclk_i or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            cread_s1 <= 1'b0;
            cread <= 1'b0;
            rdy_s1 <= 1'b0;
            rdy_l <= 1'b0;
        end
        else
        begin
            cread_s1 <= mode_reg[0];
            cread <= cread_s1;
            rdy_s1 <= ready;
            rdy_l <= rdy_s1;
        end
    end

    assign dout_oe_o = !cs_n_i;
    assign dout_o = (state == ST_READ) ? out_sr[DATA_W-1] : ~ready;

    // ------------------------------------------------
    // Crossing buffer and core domain
    // ------------------------------------------------
    wr_buffer u_buf (
        .mclk_i(mclk_i),
        .rst_n(rst_n),
        .in_valid_i(wr_ev),
        .in_ready_o(buf_in_ready),
        .in_data_i(wr_word),
        .out_valid_o(buf_out_valid),
        .out_ready_i(1'b1),
        .out_data_o(buf_out)
    );

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {rd_tg_s1, rd_tg_s2, rd_tg_s3} <= 3'h0;
            {rs_tg_s1, rs_tg_s2, rs_tg_s3} <= 3'h0;
            {wr_tg_s1, wr_tg_s2, wr_tg_s3} <= 3'h0;
        end
        else
        begin
            rd_tg_s1 <= rd_tg;
            rd_tg_s2 <= rd_tg_s1;
            rd_tg_s3 <= rd_tg_s2;
            rs_tg_s1 <= rs_tg;
            rs_tg_s2 <= rs_tg_s1;
            rs_tg_s3 <= rs_tg_s2;
            wr_tg_s1 <= wr_valid;
            wr_tg_s2 <= wr_tg_s1;
            wr_tg_s3 <= wr_tg_s2;
        end
    end

    assign data_read_ev = rd_tg_s2 ^ rd_tg_s3;
    assign wipe_ev = rs_tg_s2 ^ rs_tg_s3;
    assign wr_ev = wr_tg_s2 ^ wr_tg_s3;

    always_comb
    begin
        next_ready = ready;
        next_data_reg = data_reg;
        next_mode_reg = mode_reg;
        if (data_read_ev)
        begin
            next_ready = 1'b0;
        end
        if (pre_update_i)
        begin
            next_ready = 1'b0;
        end
        if (conv_done_i)
        begin
            next_ready = 1'b1;
            next_data_reg = conv_data_i;
        end
        if (buf_out_valid && buf_out.rs == RS_MODE)
        begin
            next_mode_reg = buf_out.value;
        end
        if (wipe_ev)
        begin
            next_ready = 1'b0;
            next_data_reg = '0;
            next_mode_reg = MODE_RESET;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready <= 1'b0;
            data_reg <= '0;
            mode_reg <= MODE_RESET;
            part_reset_o <= 1'b0;
        end
        else
        begin
            ready <= next_ready;
            data_reg <= next_data_reg;
            mode_reg <= next_mode_reg;
            part_reset_o <= wipe_ev;
        end
    end

    assign mode_reg_o = mode_reg;

    chk_done_sets_ready: assert property (@(posedge mclk_i) disable iff (!rst_n)
        conv_done_i |=> ready) else $error("ready not set after conversion");
    chk_read_clears: assert property (@(posedge mclk_i) disable iff (!rst_n)
        data_read_ev && !conv_done_i |=> !ready) else $error("ready kept after read");
    chk_update_drop: assert property (@(posedge mclk_i) disable iff (!rst_n)
        pre_update_i && !conv_done_i |=> !ready) else $error("ready kept before update");
    chk_pin_release: assert property (@(posedge mclk_i) disable iff (!rst_n)
        cs_n_i |-> !dout_oe_o) else $error("pin driven while deselected");
    chk_wipe_mode: assert property (@(posedge mclk_i) disable iff (!rst_n)
        wipe_ev |=> mode_reg == MODE_RESET && part_reset_o) else $error("wipe missed");
    chk_buf_room: assert property (@(posedge mclk_i) disable iff (!rst_n)
        wr_ev |-> buf_in_ready) else $error("write buffer full");
endmodule
`default_nettype wire

// *** core/wr_buffer.sv ***
// Two-entry buffer carrying register writes between domains
`default_nettype none
module wr_buffer
    import adc_port_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire wr_word_t in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output wr_word_t out_data_o
);
    wr_word_t mem [BUF_DEPTH];
    logic wp;
    logic rp;
    logic [1:0] count;
    logic next_wp;
    logic next_rp;
    logic [1:0] count_n;
    wr_word_t rd_q;
    wr_word_t next_rd_q;
    logic do_wr;
    logic do_rd;

    always_comb
    begin
        do_wr = in_valid_i && (count != 2'h2);
        do_rd = out_ready_i && (count != 2'h0);
        next_wp = do_wr ? ~wp : wp;
        next_rp = do_rd ? ~rp : rp;
        count_n = count + {1'b0, do_wr} - {1'b0, do_rd};
        next_rd_q = mem[next_rp];
        if (do_wr && count == 2'h0)
        begin
            next_rd_q = in_data_i;
        end
        else if (do_wr && do_rd && count == 2'h1)
        begin
            next_rd_q = in_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp <= 1'b0;
            rp <= 1'b0;
            count <= 2'h0;
            rd_q <= '0;
        end
        else
        begin
            wp <= next_wp;
            rp <= next_rp;
            count <= count_n;
            rd_q <= next_rd_q;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (do_wr)
        begin
            mem[wp] <= in_data_i;
        end
    end

    assign in_ready_o = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o = rd_q;
endmodule
`default_nettype wire

// *** dv/host_model.sv ***
// Host side of the serial link: drives link clock, select and serial input
`default_nettype none
module host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    input wire logic dout_i,
    input wire logic dout_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam time HALF = 6ns;
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    initial
    begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o = 1'b1;
    end
    // ----------------------------------------
    // Frame control
    // ----------------------------------------
    task automatic select();
        cs_n_o = 1'b0;
        #HALF;
    endtask
    task automatic deselect();
        #HALF;
        cs_n_o = 1'b1;
        // Released line shows the inverse of the last bit
        din_o = ~din_o;
    endtask
    // ----------------------------------------
    // Bit transfer, MSB first
    // ----------------------------------------
    // drive on fall, sample on rise
    task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk_o = 1'b0;
            din_o = tx[i];
            #HALF;
            rx[i] = dout_i;
            sclk_o = 1'b1;
            #HALF;
        end
    endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Testbench for the converter serial port
`default_nettype none
module tb;
    import adc_port_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk;
    logic rst_n;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe;
    logic conv_done;
    logic pre_update;
    logic [DATA_W-1:0] conv_data;
    logic [REG_W-1:0] mode_reg;
    logic part_reset;
    logic reset_seen;
    logic [31:0] rx;
    int mismatches;
    int cmp_count;
    // ----------------------------------------
    // Clock, design and host
    // ----------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    adc_serial_port adc_serial_port_i (
        .mclk_i(mclk),
        .rst_n_i(rst_n),
        .sclk_i(sclk),
        .cs_n_i(cs_n),
        .din_i(din),
        .dout_o(dout),
        .dout_oe_o(dout_oe),
        .conv_done_i(conv_done),
        .pre_update_i(pre_update),
        .conv_data_i(conv_data),
        .mode_reg_o(mode_reg),
        .part_reset_o(part_reset)
    );
    host_model host_model_i (
        .sclk_o(sclk),
        .cs_n_o(cs_n),
        .din_o(din),
        .dout_i(dout),
        .dout_oe_i(dout_oe)
    );
    always @(posedge mclk)
    begin
        if (part_reset === 1'b1)
            reset_seen <= 1'b1;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic pulse(input logic done, input logic [DATA_W-1:0] data);
        @(posedge mclk);
        conv_data <= data;
        conv_done <= done;
        pre_update <= ~done;
        @(posedge mclk);
        conv_done <= 1'b0;
        pre_update <= 1'b0;
        wait_clk(10);
    endtask
    task automatic rd(input logic [7:0] cmd, input int n);
        host_model_i.shift({24'h00_0000, cmd}, 8, rx);
        host_model_i.shift(32'h0000_0000, n, rx);
    endtask
    task automatic end_sim();
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_ready();
        host_model_i.select();
        pulse(1'b1, 24'hA5_C396);
        check(dout, 1'b0, "ready low");
        rd(8'h08, 8);
        check(rx, 32'h0000_000C, "status ready");
        rd(8'h38, 24);
        check(rx, 32'h00A5_C396, "data word");
        wait_clk(10);
        check(dout, 1'b1, "ready after read");
        rd(8'h08, 8);
        check(rx, 32'h0000_008C, "status idle");
        rd(8'h38, 24);
        check(rx, 32'h00A5_C396, "reread word");
        host_model_i.deselect();
    endtask
    task automatic t_unread();
        host_model_i.select();
        pulse(1'b1, 24'h3C_0F81);
        check(dout, 1'b0, "ready set");
        pulse(1'b0, 24'h3C_0F81);
        check(dout, 1'b1, "unread drop");
        host_model_i.deselect();
    endtask
    task automatic t_tristate();
        wait_clk(2);
        check(dout_oe, 1'b0, "released pin");
        pulse(1'b1, 24'h12_3456);
        host_model_i.select();
        wait_clk(10);
        check(dout_oe, 1'b1, "driven pin");
        check(dout, 1'b0, "flag kept");
        rd(8'h38, 24);
        check(rx, 32'h0012_3456, "word kept");
        host_model_i.deselect();
    endtask
    task automatic t_write();
        host_model_i.select();
        host_model_i.shift(32'h0000_000F, 4, rx);
        host_model_i.shift(32'h0000_105A, 16, rx);
        wait_clk(20);
        check(mode_reg, 8'h5A, "mode write");
        rd(8'h18, 8);
        check(rx, 32'h0000_005A, "mode read");
        host_model_i.deselect();
    endtask
    task automatic t_reset32();
        host_model_i.select();
        host_model_i.shift(32'hFFFF_FFFF, 32, rx);
        host_model_i.shift(32'h0000_00FF, 8, rx);
        wait_clk(20);
        check(reset_seen, 1'b1, "part reset");
        check(mode_reg, 8'h02, "mode default");
        rd(8'h08, 8);
        check(rx, 32'h0000_008C, "waiting state");
        host_model_i.deselect();
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        mismatches = 0;
        cmp_count = 0;
        reset_seen = 1'b0;
        rst_n = 1'b0;
        conv_done = 1'b0;
        pre_update = 1'b0;
        conv_data = 24'h00_0000;
        wait_clk(16);
        rst_n <= 1'b1;
        wait_clk(4);
        host_model_i.select();
        host_model_i.shift(32'h0000_00FF, 8, rx);
        host_model_i.deselect();
        t_ready();
        t_unread();
        t_tristate();
        t_write();
        t_reset32();
        end_sim();
    end
    initial
    begin
        wait_clk(20000);
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire

// *** pkg/adc_port_pkg.sv ***
// Constants and types for the converter serial port
`default_nettype none
package adc_port_pkg;
    localparam int DATA_W = 24;
    localparam int REG_W = 8;
    localparam int CMD_W = 8;
    localparam int RESET_ONES = 32;
    localparam int ONES_CNT_W = 6;
    localparam int BIT_CNT_W = 5;
    // Command bit positions, first bit shifted in is bit 7
    localparam int CMD_WEN_BIT = 7;
    localparam int CMD_RS_HI = 5;
    localparam int CMD_RS_LO = 4;
    localparam int CMD_RW_BIT = 3;
    localparam int CMD_CREAD_BIT = 2;
    // Register select codes
    localparam logic [1:0] RS_COMM = 2'h0;
    localparam logic [1:0] RS_MODE = 2'h1;
    localparam logic [1:0] RS_DATA = 2'h3;
    localparam logic [1:0] RS_STATUS = 2'h0;
    // Reset values, status layout and buffer depth
    localparam logic [7:0] MODE_RESET = 8'h02;
    localparam logic [7:0] STATUS_BASE = 8'h0C;
    localparam int STATUS_RDY_BIT = 7;
    localparam int BUF_DEPTH = 2;

    // Word handed from the link to the core domain
    typedef struct packed {
        logic [1:0] rs;
        logic [REG_W-1:0] value;
    } wr_word_t;

    typedef enum logic [1:0] {
        ST_CMD = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ = 2'b10
    } link_state_t;
endpackage
`default_nettype wire
